// ==== hdl/byte_skid.v ====
// two-entry buffer with valid and ready on both sides
`timescale 1ns/1ps
module byte_skid #(
    parameter WIDTH = 26
) (
    // clock and reset
    input  wire             clk,
    input  wire             sys_rst,
    input  wire             ce,
    // fill side
    input  wire             in_valid,
    output wire             in_ready,
    input  wire [WIDTH-1:0] in_data,
    // drain side
    output wire             out_valid,
    input  wire             out_ready,
    output reg  [WIDTH-1:0] out_data
);
    reg [WIDTH-1:0] spare_q;
    reg             full0_q;
    reg             full1_q;

    assign in_ready  = ~full1_q;
    assign out_valid = full0_q;

    // head register drives out_data, spare holds a word during a stall
    always @(posedge clk) begin
        if (sys_rst) begin
            full0_q  <= 1'b0;
            full1_q  <= 1'b0;
            out_data <= {WIDTH{1'b0}};
            spare_q  <= {WIDTH{1'b0}};
        end else if (ce) begin
            if (full0_q && out_ready) begin
                if (full1_q) begin
                    // in_ready is low while full, so a waiting word is not taken twice
                    out_data <= spare_q;
                    full1_q  <= 1'b0;
                end else if (in_valid) begin
                    out_data <= in_data;
                end else begin
                    full0_q <= 1'b0;
                end
            end else if (in_valid && !full1_q) begin
                if (!full0_q) begin
                    out_data <= in_data;
                    full0_q  <= 1'b1;
                end else begin
                    spare_q <= in_data;
                    full1_q <= 1'b1;
                end
            end
        end
    end
endmodule // byte_skid

// ==== hdl/spi_nvm_defines.vh ====
// constants for the serial nonvolatile memory command engine
`ifndef SPI_NVM_DEFINES_VH
`define SPI_NVM_DEFINES_VH
// ************************************************************
// opcodes
// ************************************************************
`define OP_WRITE_ENABLE   8'h06
`define OP_WRITE_DISABLE  8'h04
`define OP_STATUS_READ    8'h05
`define OP_STATUS_WRITE   8'h01
`define OP_MEM_READ       8'h03
`define OP_FAST_READ      8'h0B
`define OP_MEM_WRITE      8'h02
// ************************************************************
// status register layout
// ************************************************************
`define ST_PIN_EN_BIT     7
`define ST_BP_HIGH_BIT    3
`define ST_BP_LOW_BIT     2
`define ST_WEL_BIT        1
`define ST_FIXED_ONE      8'h40
`define ST_WRITABLE_MASK  8'h8C
`define ST_RESET          8'h40
// ************************************************************
// array and protected ranges
// ************************************************************
`define ADDR_W            18
`define ADDR_LAST         18'h3FFFF
`define PROT_QUARTER      18'h30000
`define PROT_HALF         18'h20000
`endif

// ==== hdl/spi_nvm_engine.v ====
// command engine of a serial nonvolatile memory acting as spi slave
`timescale 1ns/1ps
`include "spi_nvm_defines.vh"
module spi_nvm_engine #(
    parameter ADDR_W = `ADDR_W
) (
    // clock, reset, enable
    input  wire              clk,
    input  wire              sys_rst,
    input  wire              ce,
    // spi pins from the master
    input  wire              cs_n,
    input  wire              sck,
    input  wire              si,
    input  wire              wp_n,
    // spi serial output
    output reg               so_out,
    output reg               so_oe,
    // array write request, buffered
    output wire              mem_wr_valid,
    input  wire              mem_wr_ready,
    output wire [ADDR_W-1:0] mem_wr_addr,
    output wire [7:0]        mem_wr_data,
    // array read port, combinational data expected
    output reg  [ADDR_W-1:0] mem_rd_addr,
    input  wire [7:0]        mem_rd_data,
    // nonvolatile protect bits: load at reset, store on each accepted status write
    input  wire [2:0]        nv_prot_in,
    output reg  [2:0]        nv_prot_out,
    output reg               nv_prot_store,
    // status visible to system
    output wire [7:0]        status_byte
);
    // ************************************************************
    // states
    // ************************************************************
    localparam ST_OPC   = 3'd0;
    localparam ST_ADDR  = 3'd1;
    localparam ST_DUMMY = 3'd2;
    localparam ST_RDAT  = 3'd3;
    localparam ST_WDAT  = 3'd4;
    localparam ST_SWR   = 3'd5;
    localparam ST_SRD   = 3'd6;
    localparam ST_IDLE  = 3'd7;

    // ************************************************************
    // pin synchronisers
    // ************************************************************
    reg  [3:0] sync1_q;
    reg  [3:0] sync2_q;
    reg        sck_prev_q;
    reg        cs_prev_q;
    wire       cs_n_s = sync2_q[0];
    wire       sck_s  = sync2_q[1];
    wire       si_s   = sync2_q[2];
    wire       wp_n_s = sync2_q[3];
    wire       sck_rise = sck_s & ~sck_prev_q & ~cs_n_s;
    wire       sck_fall = ~sck_s & sck_prev_q & ~cs_n_s;
    wire       cs_fall  = ~cs_n_s & cs_prev_q;
    wire       cs_rise  = cs_n_s & ~cs_prev_q;

    // two flops per pin before any logic looks at them
    always @(posedge clk) begin
        if (sys_rst) begin
            sync1_q    <= 4'h9;                                           // idle pin levels
            sync2_q    <= 4'h9;                                           // no false edge
            sck_prev_q <= 1'b0;
            cs_prev_q  <= 1'b1;
        end else if (ce) begin
            sync1_q    <= {wp_n, si, sck, cs_n};
            sync2_q    <= sync1_q;
            sck_prev_q <= sck_s;
            cs_prev_q  <= cs_n_s;
        end
    end

    // ************************************************************
    // command engine
    // ************************************************************
    reg [2:0]        state_q;
    reg [7:0]        opc_q;
    reg [7:0]        shift_q;
    reg [2:0]        bit_q;
    reg [1:0]        abyte_q;
    reg [ADDR_W-1:0] addr_q;
    reg [7:0]        tx_q;
    reg              wel_q;
    reg              pin_en_q;
    reg [1:0]        bp_q;
    reg              clr_wel_q;
    reg              stopped_q;
    reg              loaded_q;
    reg              push_q;
    reg [ADDR_W-1:0] push_addr_q;
    reg [7:0]        push_data_q;
    wire [7:0]       rx_byte = {shift_q[6:0], si_s};
    wire             byte_end = sck_rise && (bit_q == 3'd7);
    wire             push_ready;
    wire             wp_hit;

    // fixed bits always read back at their fixed values
    assign status_byte = `ST_FIXED_ONE |
                         ({pin_en_q, 3'b000, bp_q, wel_q, 1'b0} & 8'h8E);

    // protected range decode from the block protect pair
    assign wp_hit = (bp_q == 2'b11) ||
                    (bp_q == 2'b10 && addr_q >= `PROT_HALF) ||
                    (bp_q == 2'b01 && addr_q >= `PROT_QUARTER);

    // status write refused when pin protect is active or latch clear
    wire swr_ok = wel_q && !(pin_en_q && !wp_n_s);

    // main sequencer, command actions keyed to sampled sck and cs edges
    always @(posedge clk) begin
        if (sys_rst) begin
            state_q       <= ST_IDLE;
            opc_q         <= 8'h00;
            shift_q       <= 8'h00;
            bit_q         <= 3'd0;
            abyte_q       <= 2'd0;
            addr_q        <= {ADDR_W{1'b0}};
            tx_q          <= 8'h00;
            wel_q         <= 1'b0;
            pin_en_q      <= 1'b0;
            bp_q          <= 2'b00;
            clr_wel_q     <= 1'b0;
            stopped_q     <= 1'b0;
            loaded_q      <= 1'b0;
            push_q        <= 1'b0;
            push_addr_q   <= {ADDR_W{1'b0}};
            push_data_q   <= 8'h00;
            nv_prot_out   <= 3'b000;
            nv_prot_store <= 1'b0;
        end else if (ce) begin
            nv_prot_store <= 1'b0;
            if (push_q && push_ready)
                push_q <= 1'b0;
            // nonvolatile protect bits restored once after reset
            if (!loaded_q) begin
                loaded_q <= 1'b1;
                {pin_en_q, bp_q} <= nv_prot_in;
            end
            if (cs_fall) begin
                state_q   <= ST_OPC;
                bit_q     <= 3'd0;
                clr_wel_q <= 1'b0;
                stopped_q <= 1'b0;
            end else if (cs_rise) begin
                // partial byte simply dropped with the state
                state_q <= ST_IDLE;
                if (clr_wel_q)
                    wel_q <= 1'b0;
                clr_wel_q <= 1'b0;
            end else if (sck_rise && state_q != ST_IDLE) begin
                bit_q   <= bit_q + 3'd1;
                shift_q <= rx_byte;
                if (byte_end) begin
                    case (state_q)
                        ST_OPC: begin
                            opc_q   <= rx_byte;
                            abyte_q <= 2'd0;
                            case (rx_byte)
                                `OP_WRITE_ENABLE: begin
                                    wel_q   <= 1'b1;
                                    state_q <= ST_IDLE;
                                end
                                `OP_WRITE_DISABLE: begin
                                    wel_q   <= 1'b0;
                                    state_q <= ST_IDLE;
                                end
                                `OP_STATUS_READ: begin
                                    tx_q    <= status_byte;
                                    state_q <= ST_SRD;
                                end
                                `OP_STATUS_WRITE: begin
                                    clr_wel_q <= 1'b1;
                                    state_q   <= ST_SWR;
                                end
                                `OP_MEM_READ, `OP_FAST_READ, `OP_MEM_WRITE: begin
                                    state_q <= ST_ADDR;
                                    if (rx_byte == `OP_MEM_WRITE)
                                        clr_wel_q <= 1'b1;
                                end
                                default: state_q <= ST_IDLE;
                            endcase
                        end
                        ST_ADDR: begin
                            // upper six bits fall off the top
                            addr_q  <= {addr_q[ADDR_W-9:0], rx_byte};
                            abyte_q <= abyte_q + 2'd1;
                            if (abyte_q == 2'd2) begin
                                if (opc_q == `OP_MEM_WRITE)
                                    state_q <= ST_WDAT;
                                else if (opc_q == `OP_FAST_READ)
                                    state_q <= ST_DUMMY;
                                else
                                    state_q <= ST_RDAT;
                            end
                        end
                        ST_DUMMY: state_q <= ST_RDAT;
                        ST_SWR: begin
                            if (swr_ok) begin
                                pin_en_q      <= rx_byte[`ST_PIN_EN_BIT];
                                bp_q          <= {rx_byte[`ST_BP_HIGH_BIT],
                                                  rx_byte[`ST_BP_LOW_BIT]};
                                nv_prot_out   <= {rx_byte[`ST_PIN_EN_BIT],
                                                  rx_byte[`ST_BP_HIGH_BIT],
                                                  rx_byte[`ST_BP_LOW_BIT]};
                                nv_prot_store <= 1'b1;
                            end
                            state_q <= ST_IDLE;
                        end
                        ST_WDAT: begin
                            // pin never gates the array; protect stops burst
                            if (!wel_q || stopped_q || wp_hit) begin
                                stopped_q <= 1'b1;
                            end else begin
                                push_q      <= 1'b1;
                                push_addr_q <= addr_q;
                                push_data_q <= rx_byte;
                                addr_q      <= addr_q + 1'b1;
                            end
                        end
                        ST_RDAT: addr_q <= addr_q + 1'b1;
                        default: state_q <= ST_IDLE;
                    endcase
                end
            end
        end
    end

    // ************************************************************
    // serial output
    // ************************************************************
    wire shifting_out = (state_q == ST_RDAT) || (state_q == ST_SRD);

    // output changes on sck fall; si is never sampled into data here
    always @(posedge clk) begin
        if (sys_rst) begin
            so_out      <= 1'b0;
            so_oe       <= 1'b0;
            mem_rd_addr <= {ADDR_W{1'b0}};
        end else if (ce) begin
            mem_rd_addr <= addr_q;
            if (cs_n_s || !shifting_out) begin
                so_oe <= 1'b0;
            end else if (sck_fall) begin
                so_oe <= 1'b1;
                if (state_q == ST_SRD)
                    so_out <= tx_q[3'd7 - bit_q];
                else
                    so_out <= mem_rd_data[3'd7 - bit_q];
            end
        end
    end

    // ************************************************************
    // write buffer toward the array
    // ************************************************************
    // a stalled array loses nothing while at most three bytes are pending; the third waits in push_q, a fourth overwrites it
    byte_skid #(
        .WIDTH(ADDR_W + 8)
    ) u_wbuf (
        .clk      (clk),
        .sys_rst  (sys_rst),
        .ce       (ce),
        .in_valid (push_q),
        .in_ready (push_ready),
        .in_data  ({push_addr_q, push_data_q}),
        .out_valid(mem_wr_valid),
        .out_ready(mem_wr_ready),
        .out_data ({mem_wr_addr, mem_wr_data})
    );
endmodule // spi_nvm_engine

// ==== tb/spi_master_model.sv ====
// spi bus master model, mode 0, clock still between frames
`timescale 1ns/1ps
module spi_master_model (
    // system clock used for pacing
    input  wire clk,
    // spi pins
    output reg  cs_n,
    output reg  sck,
    output reg  si,
    input  wire so
);
    // ************************************************************
    // bus tasks
    // ************************************************************
    initial begin
        cs_n = 1'b1;
        sck  = 1'b0;
        si   = 1'b0;
    end
    // all pin changes land on falling clk edges, four clocks per sck phase
    task automatic hold(input int n);
        repeat (n) @(negedge clk);
    endtask
    task automatic start;
        hold(1);
        cs_n = 1'b0;
        hold(4);
    endtask
    // released data line flips so a stale bit never looks valid
    task automatic stop;
        hold(4);
        cs_n = 1'b1;
        si   = ~si;
        hold(8);
    endtask
    task automatic bits(input [7:0] tx, input int n, output [7:0] rx);
        int i;
        rx = 8'h00;
        for (i = 7; i >= 8 - n; i--) begin // msb first
            si = tx[i];
            hold(4);
            sck = 1'b1;
            rx = {rx[6:0], so};
            hold(4);
            sck = 1'b0;
        end
    endtask
endmodule // spi_master_model

// ==== tb/spi_memory_write_protect_access_tb.sv ====
// self-checking testbench for the serial memory command engine
`timescale 1ns/1ps
`define CHECK(a, e) begin n_tests++; if ((a) !== (e)) begin n_errors++; \
    $display("unexpected at %0t: got %h want %h", $time, a, e); end end
module spi_memory_write_protect_access_tb;
    // ************************************************************
    // signals and models
    // ************************************************************
    reg         clk, sys_rst, wp_n, mem_wr_ready;
    reg  [2:0]  nv_prot_in;
    wire        cs_n, sck, si, so_out, so_oe, mem_wr_valid, nv_prot_store;
    wire [17:0] mem_wr_addr, mem_rd_addr;
    wire [7:0]  mem_wr_data, mem_rd_data, status_byte;
    wire [2:0]  nv_prot_out;
    wire        so_line = so_oe ? so_out : 1'bz;
    reg  [7:0]  mem [0:262143];
    reg  [7:0]  ref_mem [0:262143];
    reg  [7:0]  st_exp, rx;
    reg  [15:0] lfsr = 16'h0058;
    int         n_errors = 0, n_tests = 0, cycles = 0, i, bp;
    reg  [17:0] base;
    reg  [7:0]  r8;
    spi_nvm_engine #(.ADDR_W(18)) dut (.clk(clk), .sys_rst(sys_rst), .ce(1'b1), .cs_n(cs_n),
        .sck(sck), .si(si), .wp_n(wp_n), .so_out(so_out), .so_oe(so_oe),
        .mem_wr_valid(mem_wr_valid), .mem_wr_ready(mem_wr_ready), .mem_wr_addr(mem_wr_addr),
        .mem_wr_data(mem_wr_data), .mem_rd_addr(mem_rd_addr), .mem_rd_data(mem_rd_data),
        .nv_prot_in(nv_prot_in), .nv_prot_out(nv_prot_out), .nv_prot_store(nv_prot_store),
        .status_byte(status_byte));
    spi_master_model master (.clk(clk), .cs_n(cs_n), .sck(sck), .si(si), .so(so_line));
    // array model: combinational read, writes taken when ready
    assign mem_rd_data = mem[mem_rd_addr];
    always @(posedge clk) begin
        if (mem_wr_valid && mem_wr_ready) mem[mem_wr_addr] <= mem_wr_data;
    end
    // array stalls about one cycle in four so the buffer gets exercised
    always @(negedge clk) mem_wr_ready <= (rnd() & 8'h03) != 8'h00;
    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end
    // hang guard, well above the expected run of about 12100 cycles
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 40000) begin
            n_errors++;
            stop_test;
        end
    end
    // ************************************************************
    // helpers
    // ************************************************************
    function automatic logic [7:0] rnd();
        lfsr = {lfsr[14:0], lfsr[15] ^ lfsr[13] ^ lfsr[12] ^ lfsr[10]};
        return lfsr[7:0];
    endfunction
    function automatic bit prot(input [17:0] a);
        return st_exp[3:2] == 2'b11 || (st_exp[3:2] == 2'b10 && a >= 18'h20000)
            || (st_exp[3:2] == 2'b01 && a >= 18'h30000);
    endfunction
    task automatic hdr(input [7:0] op, input [23:0] a);
        master.start;
        master.bits(op, 8, rx);
        master.bits(a[23:16], 8, rx);
        master.bits(a[15:8], 8, rx);
        master.bits(a[7:0], 8, rx);
    endtask
    task automatic cmd(input [7:0] op);
        master.start;
        master.bits(op, 8, rx);
        master.stop;
    endtask
    task automatic status;
        master.start;
        master.bits(8'h05, 8, rx);
        master.bits(rnd(), 8, rx);
        master.stop;
        `CHECK(rx, st_exp)
        `CHECK(status_byte, st_exp)
    endtask
    task automatic status_write_cmd(input [7:0] d, input bit en);
        if (en) cmd(8'h06);
        master.start;
        master.bits(8'h01, 8, rx);
        master.bits(d, 8, rx);
        master.stop;
        if (en && !(st_exp[7] && !wp_n)) st_exp = (d & 8'h8C) | 8'h40;
        st_exp[1] = 1'b0;
        `CHECK(nv_prot_out, {st_exp[7], st_exp[3:2]})
    endtask
    // four data bytes then a cut-short byte that must leave no trace
    task automatic wr(input [23:0] a, input bit en);
        reg [17:0] ad;
        reg [7:0]  d;
        bit        halt;
        int        k;
        if (en) cmd(8'h06);
        ad = a[17:0];
        halt = !en;
        hdr(8'h02, a);
        for (k = 0; k < 4; k++) begin
            d = rnd();
            master.bits(d, 8, rx);
            halt = halt | prot(ad);
            if (!halt) ref_mem[ad] = d;
            if (!halt) ad = ad + 18'h1;
        end
        master.bits(rnd(), 4, rx);
        master.stop;
        st_exp[1] = 1'b0;
    endtask
    task automatic rd(input [7:0] op, input [23:0] a);
        reg [17:0] ad;
        int        k;
        ad = a[17:0];
        hdr(op, a);
        if (op == 8'h0B) master.bits(rnd(), 8, rx);
        for (k = 0; k < 5; k++) begin
            master.bits(rnd(), 8, rx);
            `CHECK(rx, ref_mem[ad])
            ad = ad + 18'h1;
        end
        master.stop;
    endtask
    task stop_test;
        $display("errors %0d tests %0d", n_errors, n_tests);
        if (n_errors == 0 && n_tests > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    // ************************************************************
    // main sequence
    // ************************************************************
    initial begin
        sys_rst = 1'b1;
        wp_n = 1'b1;
        nv_prot_in = 3'h0;
        st_exp = 8'h40;
        for (i = 0; i < 262144; i++) mem[i] = i[7:0] ^ 8'hA5;
        for (i = 0; i < 262144; i++) ref_mem[i] = mem[i];
        repeat (20) @(negedge clk);
        sys_rst = 1'b0;
        repeat (5) @(negedge clk);
        status;
        cmd(8'hFF);
        status;
        cmd(8'h06);
        st_exp[1] = 1'b1;
        status;
        cmd(8'h04);
        st_exp[1] = 1'b0;
        status;
        wr(24'h000100, 1'b0);
        rd(8'h03, 24'h000100);
        status_write_cmd(8'hFF, 1'b1);
        status;
        wp_n = 1'b0;
        status_write_cmd(8'h00, 1'b1);
        wp_n = 1'b1;
        status_write_cmd(8'h08, 1'b0);
        status;
        for (bp = 0; bp < 4; bp++) begin
            status_write_cmd({4'h0, bp[1:0], 2'b00}, 1'b1);
            wp_n = rnd() > 8'h7F;
            base = bp == 1 ? 18'h2FFFE : bp == 2 ? 18'h1FFFE : 18'h3FFFE;
            r8 = rnd();
            wr({r8[5:0], base}, 1'b1);
            status;
            r8 = rnd();
            rd(8'h03, {r8[5:0], base});
            r8 = rnd();
            rd(8'h0B, {r8[5:0], base});
            wp_n = 1'b1;
        end
        @(negedge clk);
        nv_prot_in = nv_prot_out;
        sys_rst = 1'b1;
        repeat (20) @(negedge clk);
        sys_rst = 1'b0;
        repeat (5) @(negedge clk);
        status;
        for (i = 0; i < 262144; i++) `CHECK(mem[i], ref_mem[i])
        stop_test;
    end
endmodule // spi_memory_write_protect_access_tb

// ==== tb/spi_nvm_checks_assertions.sv ====
// concurrent checks on the ports of the serial memory command engine
`timescale 1ns/1ps
module spi_nvm_checks #(
    parameter ADDR_W = 18
) (
    // clock and reset
    input wire              clk,
    input wire              sys_rst,
    // spi pins
    input wire              cs_n,
    input wire              so_oe,
    // array write side
    input wire              mem_wr_valid,
    input wire              mem_wr_ready,
    input wire [ADDR_W-1:0] mem_wr_addr,
    input wire [7:0]        mem_wr_data,
    // protect bits and status
    input wire [2:0]        nv_prot_out,
    input wire              nv_prot_store,
    input wire [7:0]        status_byte
);
    // ************************************************************
    // checks
    // ************************************************************
    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);
    // locked range: all, the upper half or the upper quarter of the array
    function automatic logic locked(input [ADDR_W-1:0] a, input [1:0] bp);
        locked = (bp == 2'b11) || (bp == 2'b10 && a[ADDR_W-1])
              || (bp == 2'b01 && a[ADDR_W-1 -: 2] == 2'b11);
    endfunction
    so_release_a: assert property (cs_n [*5] |=> !so_oe)
        else $error("serial output still driven while deselected");
    so_start_a: assert property ($rose(so_oe) |-> !cs_n)
        else $error("serial output driven without select");
    wr_hold_a: assert property (mem_wr_valid && !mem_wr_ready |=> mem_wr_valid
        && $stable(mem_wr_addr) && $stable(mem_wr_data)) else $error("write request dropped");
    wr_locked_a: assert property (mem_wr_valid |-> !locked(mem_wr_addr, status_byte[3:2]))
        else $error("write to a locked address");
    fixed_bits_a: assert property ((status_byte & 8'h71) == 8'h40)
        else $error("fixed status bits wrong");
    store_pulse_a: assert property (nv_prot_store |=> !nv_prot_store)
        else $error("store pulse too long");
    store_value_a: assert property (nv_prot_store |-> ##[0:2]
        (nv_prot_out == {status_byte[7], status_byte[3:2]})) else $error("stored bits differ");
    latch_set_a: assert property ($rose(status_byte[1]) |-> !$past(cs_n, 5))
        else $error("latch set outside a frame");
endmodule // spi_nvm_checks

bind spi_nvm_engine spi_nvm_checks #(.ADDR_W(ADDR_W)) checks (
    .clk(clk), .sys_rst(sys_rst), .cs_n(cs_n), .so_oe(so_oe), .mem_wr_valid(mem_wr_valid),
    .mem_wr_ready(mem_wr_ready), .mem_wr_addr(mem_wr_addr), .mem_wr_data(mem_wr_data),
    .nv_prot_out(nv_prot_out), .nv_prot_store(nv_prot_store), .status_byte(status_byte));
